//--- core/crc_engine.sv
// crc_engine: byte-stream crc unit with axi4-lite registers and flash auto mode
// assumes: flash read port and cpu stall on the same clock as the bus
`timescale 1ns/1ps
module crc_engine
#(
    parameter int PAGE_W  = 8,
    parameter int COUNT_W = 8
) (
    input  wire logic                     i_clock,
    input  wire logic                     i_reset_n,
    input  wire logic [7:0]               i_axi_awaddr,
    input  wire logic                     i_axi_awvalid,
    output logic                          o_axi_awready,
    input  wire logic [31:0]              i_axi_wdata,
    input  wire logic [3:0]               i_axi_wstrb,
    input  wire logic                     i_axi_wvalid,
    output logic                          o_axi_wready,
    output logic [1:0]                    o_axi_bresp,
    output logic                          o_axi_bvalid,
    input  wire logic                     i_axi_bready,
    input  wire logic [7:0]               i_axi_araddr,
    input  wire logic                     i_axi_arvalid,
    output logic                          o_axi_arready,
    output logic [31:0]                   o_axi_rdata,
    output logic [1:0]                    o_axi_rresp,
    output logic                          o_axi_rvalid,
    input  wire logic                     i_axi_rready,
    output logic                          o_flash_rd_req,
    output logic [PAGE_W+crc_unit_pkg::SECTOR_SHIFT-1:0] o_flash_addr,
    input  wire logic                     i_flash_ack,
    input  wire logic [7:0]               i_flash_data,
    output logic                          o_cpu_stall
);
    import crc_unit_pkg::*;

    localparam int AW = PAGE_W + SECTOR_SHIFT;
    localparam int RW = COUNT_W + SECTOR_SHIFT;

    logic                aw_hold_reg;
    logic [7:0]          awaddr_reg;
    logic                w_hold_reg;
    logic [31:0]         wdata_reg;
    logic [3:0]          wstrb_reg;
    logic                bvalid_reg;
    logic [1:0]          bresp_reg;
    logic                rvalid_reg;
    logic [31:0]         rdata_reg;
    logic [1:0]          rresp_reg;
    logic                poly_sel_reg;
    logic                start_val_reg;
    logic [1:0]          pointer_reg;
    logic [7:0]          byte_in_reg;
    logic [31:0]         remainder_reg;
    logic                auto_enable_reg;
    logic [PAGE_W-1:0]   page_reg;
    logic [COUNT_W-1:0]  sector_count_reg;
    logic [7:0]          reverse_reg;
    auto_state_t         state_reg;
    logic [AW-1:0]       flash_addr_reg;
    logic [RW-1:0]       remaining_reg;
    logic                do_write;
    logic                rd_fire;
    logic                wr_ctrl;
    logic                wr_byte;
    logic                wr_data;
    logic                rd_data;
    logic                auto_start;
    logic                flash_fold;
    logic [1:0]          byte_index;
    logic [7:0]          step_byte;
    logic [31:0]         step_result;
    logic [31:0]         preset_value;
    logic [7:0]          reverse_view;
    logic [31:0]         rd_value;
    logic                rd_mapped;

    assign o_axi_awready  = !aw_hold_reg && !bvalid_reg;
    assign o_axi_wready   = !w_hold_reg && !bvalid_reg;
    assign o_axi_bvalid   = bvalid_reg;
    assign o_axi_bresp    = bresp_reg;
    assign o_axi_arready  = !rvalid_reg;
    assign o_axi_rvalid   = rvalid_reg;
    assign o_axi_rdata    = rdata_reg;
    assign o_axi_rresp    = rresp_reg;
    assign o_flash_rd_req = (state_reg == ST_READ);
    assign o_flash_addr   = flash_addr_reg;
    assign o_cpu_stall    = (state_reg == ST_READ);

    assign do_write   = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign rd_fire    = i_axi_arvalid && !rvalid_reg;
    assign wr_ctrl    = do_write && awaddr_reg == CONTROL_OFFSET && wstrb_reg[0];
    assign wr_byte    = do_write && awaddr_reg == BYTE_INPUT_OFFSET && wstrb_reg[0]
                        && state_reg == ST_IDLE;
    assign wr_data    = do_write && awaddr_reg == RESULT_DATA_OFFSET && wstrb_reg[0];
    assign rd_data    = rd_fire && i_axi_araddr == RESULT_DATA_OFFSET;
    assign auto_start = wr_ctrl && auto_enable_reg && state_reg == ST_IDLE;
    assign flash_fold = state_reg == ST_READ && i_flash_ack;
    assign byte_index = poly_sel_reg ? {1'b0, pointer_reg[0]} : pointer_reg;
    assign step_byte  = flash_fold ? i_flash_data : wdata_reg[7:0];
    assign preset_value = wdata_reg[START_VAL_BIT] ? PRESET_ONES : PRESET_ZEROS;

    crc_byte_step step_inst (
        .i_remainder (remainder_reg),
        .i_byte      (step_byte),
        .i_sel_16    (poly_sel_reg),
        .o_remainder (step_result)
    );

    generate
        for (genvar b = 0; b < 8; b++) begin : g_rev
            assign reverse_view[b] = reverse_reg[7-b];
        end
    endgenerate

    // write address and data capture, response
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            aw_hold_reg <= 1'b0;
            awaddr_reg  <= 8'h00;
            w_hold_reg  <= 1'b0;
            wdata_reg   <= 32'h00000000;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else begin
            if (i_axi_awvalid && o_axi_awready) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= i_axi_awaddr;
            end
            if (i_axi_wvalid && o_axi_wready) begin
                w_hold_reg <= 1'b1;
                wdata_reg  <= i_axi_wdata;
                wstrb_reg  <= i_axi_wstrb;
            end
            if (do_write) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= (awaddr_reg <= BIT_REVERSE_OFFSET && awaddr_reg[1:0] == 2'b00)
                               ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_reg && i_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // read data mux
    always_comb begin
        rd_value  = 32'h00000000;
        rd_mapped = 1'b1;
        case (i_axi_araddr)
            CONTROL_OFFSET: begin
                rd_value[POLY_SEL_BIT]            = poly_sel_reg;
                rd_value[START_VAL_BIT]           = start_val_reg;
                rd_value[POINTER_LSB+1:POINTER_LSB] = pointer_reg;
            end
            BYTE_INPUT_OFFSET:   rd_value[7:0] = byte_in_reg;
            RESULT_DATA_OFFSET:  rd_value[7:0] = remainder_reg[byte_index*8 +: 8];
            AUTO_CONTROL_OFFSET: begin
                rd_value[AUTO_ENABLE_BIT]          = auto_enable_reg;
                rd_value[PAGE_LSB+PAGE_W-1:PAGE_LSB] = page_reg;
            end
            SECTOR_COUNT_OFFSET: rd_value[COUNT_W-1:0] = sector_count_reg;
            BIT_REVERSE_OFFSET:  rd_value[7:0] = reverse_view;
            default:             rd_mapped = 1'b0;
        endcase
    end

    // read channel
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_value;
            rresp_reg  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_reg && i_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // control, auto and plain registers
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            poly_sel_reg     <= CONTROL_RESET[POLY_SEL_BIT];
            start_val_reg    <= CONTROL_RESET[START_VAL_BIT];
            byte_in_reg      <= BYTE_RESET;
            auto_enable_reg  <= 1'b0;
            page_reg         <= '0;
            sector_count_reg <= '0;
            reverse_reg      <= BYTE_RESET;
        end else begin
            if (wr_ctrl) begin
                poly_sel_reg  <= wdata_reg[POLY_SEL_BIT];
                start_val_reg <= wdata_reg[START_VAL_BIT];
            end
            if (wr_byte) begin
                byte_in_reg <= wdata_reg[7:0];
            end
            if (do_write && awaddr_reg == AUTO_CONTROL_OFFSET) begin
                if (wstrb_reg[0]) begin
                    page_reg <= wdata_reg[PAGE_LSB+PAGE_W-1:PAGE_LSB];
                end
                if (wstrb_reg[2]) begin
                    auto_enable_reg <= wdata_reg[AUTO_ENABLE_BIT];
                end
            end
            if (do_write && awaddr_reg == SECTOR_COUNT_OFFSET && wstrb_reg[0]) begin
                sector_count_reg <= wdata_reg[COUNT_W-1:0];
            end
            if (do_write && awaddr_reg == BIT_REVERSE_OFFSET && wstrb_reg[0]) begin
                reverse_reg <= wdata_reg[7:0];
            end
        end
    end

    // result byte pointer
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            pointer_reg <= CONTROL_RESET[POINTER_LSB+1:POINTER_LSB];
        end else if (wr_ctrl) begin
            pointer_reg <= wdata_reg[POINTER_LSB+1:POINTER_LSB];
        end else if (wr_data || rd_data) begin
            pointer_reg <= pointer_reg + 2'd1;
        end
    end

    // remainder
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            remainder_reg <= REMAINDER_RESET;
        end else if (flash_fold || wr_byte) begin
            remainder_reg <= step_result;
        end else if (wr_ctrl && wdata_reg[INIT_BIT]) begin
            remainder_reg <= preset_value;
        end else if (wr_data) begin
            remainder_reg[byte_index*8 +: 8] <= wdata_reg[7:0];
        end
    end

    // automatic flash run
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            state_reg      <= ST_IDLE;
            flash_addr_reg <= '0;
            remaining_reg  <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (auto_start && sector_count_reg != '0) begin
                        state_reg      <= ST_READ;
                        flash_addr_reg <= {page_reg, {SECTOR_SHIFT{1'b0}}};
                        remaining_reg  <= {sector_count_reg, {SECTOR_SHIFT{1'b0}}};
                    end
                end
                ST_READ: begin
                    if (i_flash_ack) begin
                        flash_addr_reg <= flash_addr_reg + AW'(1);
                        remaining_reg  <= remaining_reg - RW'(1);
                        if (remaining_reg == RW'(1)) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    property p_init_preset;
        @(posedge i_clock) disable iff (!i_reset_n)
        (wr_ctrl && wdata_reg[INIT_BIT] && !wr_byte && !flash_fold)
            |=> remainder_reg == ($past(wdata_reg[START_VAL_BIT]) ? PRESET_ONES : PRESET_ZEROS);
    endproperty
    a_init_preset: assert property (p_init_preset)
        else $error("initialise did not load the chosen preset");

    property p_ptr_advance;
        @(posedge i_clock) disable iff (!i_reset_n)
        (rd_data && !wr_ctrl) |=> pointer_reg == $past(pointer_reg) + 2'd1;
    endproperty
    a_ptr_advance: assert property (p_ptr_advance)
        else $error("pointer did not advance after result read");

    property p_stall_start;
        @(posedge i_clock) disable iff (!i_reset_n)
        (auto_start && sector_count_reg != '0) |=> o_cpu_stall [*2];
    endproperty
    a_stall_start: assert property (p_stall_start)
        else $error("cpu not stalled after auto start");

    property p_flash_order;
        @(posedge i_clock) disable iff (!i_reset_n)
        (flash_fold && remaining_reg != RW'(1)) |=>
            o_flash_rd_req && o_flash_addr == $past(o_flash_addr) + AW'(1);
    endproperty
    a_flash_order: assert property (p_flash_order)
        else $error("flash address not ascending by one");

    property p_hold;
        @(posedge i_clock) disable iff (!i_reset_n)
        (!do_write && !flash_fold) |=> $stable(remainder_reg);
    endproperty
    a_hold: assert property (p_hold)
        else $error("remainder changed with no cause");

    property p_shift16;
        @(posedge i_clock) disable iff (!i_reset_n)
        (wr_byte && poly_sel_reg && (wdata_reg[7:0] == remainder_reg[15:8]))
            |=> remainder_reg[15:0] == {$past(remainder_reg[7:0]), 8'h00};
    endproperty
    a_shift16: assert property (p_shift16)
        else $error("16-bit step wrong for cancelled top byte");

    property p_shift32;
        @(posedge i_clock) disable iff (!i_reset_n)
        (wr_byte && !poly_sel_reg && (wdata_reg[7:0] == remainder_reg[7:0]))
            |=> remainder_reg == {8'h00, $past(remainder_reg[31:8])};
    endproperty
    a_shift32: assert property (p_shift32)
        else $error("32-bit step wrong for cancelled low byte");

    property p_map16;
        @(posedge i_clock) disable iff (!i_reset_n)
        (rd_data && poly_sel_reg) |=>
            o_axi_rdata[7:0] == ($past(pointer_reg[0]) ? $past(remainder_reg[15:8])
                                                       : $past(remainder_reg[7:0]));
    endproperty
    a_map16: assert property (p_map16)
        else $error("16-bit pointer mapping wrong");
endmodule // crc_engine

//--- core/crc_unit_pkg.sv
// crc_unit_pkg: register map, field positions, reset values and constants
// assumes: shared by the byte-stream crc engine and its byte-step module
package crc_unit_pkg;
    // register byte addresses on the axi4-lite bus
    localparam logic [7:0]  CONTROL_OFFSET      = 8'h00;
    localparam logic [7:0]  BYTE_INPUT_OFFSET   = 8'h04;
    localparam logic [7:0]  RESULT_DATA_OFFSET  = 8'h08;
    localparam logic [7:0]  AUTO_CONTROL_OFFSET = 8'h0c;
    localparam logic [7:0]  SECTOR_COUNT_OFFSET = 8'h10;
    localparam logic [7:0]  BIT_REVERSE_OFFSET  = 8'h14;
    // control register fields
    localparam int          POLY_SEL_BIT        = 4;
    localparam int          INIT_BIT            = 3;
    localparam int          START_VAL_BIT       = 2;
    localparam int          POINTER_LSB         = 0;
    // auto control register fields (page index sits in the low byte)
    localparam int          AUTO_ENABLE_BIT     = 16;
    localparam int          PAGE_LSB            = 0;
    // reset values
    localparam logic [4:0]  CONTROL_RESET       = 5'h00;
    localparam logic [7:0]  BYTE_RESET          = 8'h00;
    localparam logic [31:0] REMAINDER_RESET     = 32'h00000000;
    // presets and polynomials
    localparam logic [31:0] PRESET_ZEROS        = 32'h00000000;
    localparam logic [31:0] PRESET_ONES         = 32'hffffffff;
    localparam logic [15:0] POLY_16             = 16'h1021;
    localparam logic [31:0] POLY_32             = 32'h04c11db7;
    localparam logic [31:0] POLY_32_REFLECTED   = 32'hedb88320;
    // flash sector geometry
    localparam int          SECTOR_BYTES        = 512;
    localparam int          SECTOR_SHIFT        = 9;
    // axi responses
    localparam logic [1:0]  RESP_OKAY           = 2'b00;
    localparam logic [1:0]  RESP_SLVERR         = 2'b10;

    typedef enum logic {ST_IDLE, ST_READ} auto_state_t;
endpackage

//--- core/crc_byte_step.sv
// crc_byte_step: folds one input byte into a crc remainder, combinational
// assumes: caller registers the result; upper half kept unchanged in 16-bit mode
`timescale 1ns/1ps
module crc_byte_step
(
    input  wire logic [31:0] i_remainder,
    input  wire logic [7:0]  i_byte,
    input  wire logic        i_sel_16,
    output logic      [31:0] o_remainder
);
    import crc_unit_pkg::*;

    logic [15:0] acc16;
    logic [31:0] acc32;

    always_comb begin
        acc16 = i_remainder[15:0] ^ {i_byte, 8'h00};
        acc32 = i_remainder ^ {24'h000000, i_byte};
        for (int i = 0; i < 8; i++) begin
            if (acc16[15]) begin
                acc16 = {acc16[14:0], 1'b0} ^ POLY_16;
            end else begin
                acc16 = {acc16[14:0], 1'b0};
            end
            if (acc32[0]) begin
                acc32 = {1'b0, acc32[31:1]} ^ POLY_32_REFLECTED;
            end else begin
                acc32 = {1'b0, acc32[31:1]};
            end
        end
        o_remainder = i_sel_16 ? {i_remainder[31:16], acc16} : acc32;
    end
endmodule // crc_byte_step

//--- testbench/crc_engine_bench.sv
// crc_engine_bench: self-checking bench for the byte-stream crc engine
// assumes: crc_unit_pkg and crc_engine compiled first; bench is bus master and flash
`timescale 1ns/1ps
module crc_engine_bench;
    import crc_unit_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, fl_data = 8'h00, fl_byte, page;
    logic [31:0] wdata = 32'h0, rdata, exp_crc, seed = 32'h5e1fb4cb;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, fl_ack = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, fl_req, stall;
    logic [1:0]  bresp, rresp;
    logic [16:0] fl_addr, exp_addr;
    int          fail_count = 0, checks_done = 0;
    logic [39:0] vec_in  [6] = '{40'h63, 40'haabbcc, 40'h0000aabbcc,
                                 40'h63, 40'haabbcc, 40'h0000aabbcc};
    int          vec_len [6] = '{1, 3, 5, 1, 3, 5};
    logic [31:0] vec_out [6] = '{32'hbd35, 32'h6cf6, 32'hb166,
                                 32'hf9462090, 32'h41b207b3, 32'h78d129bc};

    always #12.5 clk = ~clk;

    crc_engine #(.PAGE_W(8), .COUNT_W(8)) dut (
        .i_clock(clk), .i_reset_n(rst_n),
        .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid), .o_axi_awready(awready),
        .i_axi_wdata(wdata), .i_axi_wstrb(4'hf), .i_axi_wvalid(wvalid), .o_axi_wready(wready),
        .o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
        .i_axi_araddr(araddr), .i_axi_arvalid(arvalid), .o_axi_arready(arready),
        .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid),
        .i_axi_rready(rready), .o_flash_rd_req(fl_req), .o_flash_addr(fl_addr),
        .i_flash_ack(fl_ack), .i_flash_data(fl_data), .o_cpu_stall(stall)
    );

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // expected remainder after one byte
    function automatic logic [31:0] fold(logic [31:0] c, logic [7:0] b, logic s16);
        logic [15:0] h;
        logic [31:0] w;
        h = c[15:0] ^ {b, 8'h00};
        w = c ^ {24'h0, b};
        for (int i = 0; i < 8; i++) begin
            h = h[15] ? ((h << 1) ^ POLY_16) : (h << 1);
            w = w[0] ? ((w >> 1) ^ POLY_32_REFLECTED) : (w >> 1);
        end
        return s16 ? {c[31:16], h} : w;
    endfunction

    function automatic logic [31:0] ctrl(logic sel, logic init, logic val, logic [1:0] ptr);
        return (32'(sel) << POLY_SEL_BIT) | (32'(init) << INIT_BIT)
             | (32'(val) << START_VAL_BIT) | 32'(ptr);
    endfunction

    // expected bit-reversed byte
    function automatic logic [7:0] rev8(logic [7:0] b);
        logic [7:0] o;
        for (int i = 0; i < 8; i++) begin
            o[i] = b[7 - i];
        end
        return o;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (awvalid && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        bus_write(a, d, r);
        check(32'(r), 32'(RESP_OKAY), "write response");
    endtask

    task automatic feed(input logic [7:0] b, input logic sel);
        wr(BYTE_INPUT_OFFSET, {24'h0, b});
        exp_crc = fold(exp_crc, b, sel);
    endtask

    // reads all four pointer positions from zero
    task automatic check_result(input logic sel, input logic val, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        wr(CONTROL_OFFSET, ctrl(sel, 1'b0, val, 2'd0));
        for (int k = 0; k < 4; k++) begin
            bus_read(RESULT_DATA_OFFSET, d, r);
            check(d, {24'h0, exp[8 * (sel ? k % 2 : k) +: 8]}, "result byte");
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // flash side: acks with gaps, data toggles when idle
    always @(posedge clk) begin
        if (fl_req && !fl_ack && rnd() % 4 != 0) begin
            fl_byte = rnd();
            fl_ack  <= 1'b1;
            fl_data <= fl_byte;
            check(32'(fl_addr), 32'(exp_addr), "flash address");
            check(32'(stall), 32'h1, "cpu stall");
            exp_crc = fold(exp_crc, fl_byte, 1'b0);
            exp_addr = exp_addr + 17'd1;
        end else begin
            fl_ack  <= 1'b0;
            fl_data <= ~fl_data;
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        test_done();
    end

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic        sel;
        logic [31:0] q;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int t = 0; t < 6; t++) begin
            sel = (t < 3);
            wr(CONTROL_OFFSET, ctrl(sel, 1'b1, 1'b1, 2'd0));
            for (int j = 0; j < vec_len[t]; j++) begin
                feed(vec_in[t][8 * (vec_len[t] - 1 - j) +: 8], sel);
            end
            check_result(sel, 1'b1, vec_out[t]);
        end
        $display("test vectors done");
        for (int m = 0; m < 8; m++) begin
            wr(CONTROL_OFFSET, ctrl(m[0], 1'b1, m[1], 2'(m >> 1)));
            exp_crc = m[1] ? PRESET_ONES : PRESET_ZEROS;
            for (int j = 0; j <= m; j++) begin
                feed(rnd(), m[0]);
                if (j == 0) begin
                    // corner: byte cancels the leading remainder byte
                    feed(m[0] ? exp_crc[15:8] : exp_crc[7:0], m[0]);
                end
            end
            check_result(m[0], m[1], exp_crc);
        end
        bus_read(BYTE_INPUT_OFFSET, d, r);
        check(d, {24'h0, seed[7:0]}, "byte input readback");
        $display("test streams done");
        // overwrite through pointer starting at byte 1
        wr(CONTROL_OFFSET, ctrl(1'b0, 1'b1, 1'b0, 2'd1));
        exp_crc = 32'h0;
        for (int k = 1; k < 5; k++) begin
            d = rnd();
            exp_crc[8 * (k % 4) +: 8] = d[7:0];
            wr(RESULT_DATA_OFFSET, {24'h0, d[7:0]});
        end
        check_result(1'b0, 1'b0, exp_crc);
        feed(8'h5a, 1'b0);
        check_result(1'b0, 1'b0, exp_crc);
        $display("test overwrite done");
        d = rnd();
        wr(BIT_REVERSE_OFFSET, {24'h0, d[7:0]});
        bus_read(BIT_REVERSE_OFFSET, q, r);
        check(q, {24'h0, rev8(d[7:0])}, "bit reverse");
        bus_write(8'h18, d, r);
        check(32'(r), 32'(RESP_SLVERR), "unmapped write");
        bus_read(8'h02, d, r);
        check(d, 32'h0, "unaligned read data");
        check(32'(r), 32'(RESP_SLVERR), "unaligned read");
        $display("test registers done");
        wr(CONTROL_OFFSET, ctrl(1'b0, 1'b1, 1'b1, 2'd0));
        exp_crc = PRESET_ONES;
        page = rnd();
        wr(AUTO_CONTROL_OFFSET, 32'(page));
        wr(AUTO_CONTROL_OFFSET, 32'(page) | (32'h1 << AUTO_ENABLE_BIT));
        wr(SECTOR_COUNT_OFFSET, 32'h0);
        wr(CONTROL_OFFSET, ctrl(1'b0, 1'b0, 1'b1, 2'd0));
        repeat (3) @(posedge clk);
        check(32'(fl_req), 32'h0, "run with zero count");
        wr(SECTOR_COUNT_OFFSET, 32'h1);
        exp_addr = {page, 9'h0};
        wr(CONTROL_OFFSET, ctrl(1'b0, 1'b0, 1'b1, 2'd0));
        check(32'(stall), 32'h1, "run started");
        while (fl_req) @(posedge clk);
        check(32'(exp_addr), 32'({page, 9'h0} + 17'd512), "bytes fed");
        wr(AUTO_CONTROL_OFFSET, 32'(page));
        check_result(1'b0, 1'b1, exp_crc);
        $display("test auto run done");
        test_done();
    end

endmodule // crc_engine_bench
